//--- core/adc_trigger_control.sv
// Converter control: register file, conversion sequencer, compare
// trigger path and interrupt. Assumes an AHB-Lite master on ref_clk,
// compare-unit signals from logic on ref_clk, and an analog front end
// and RC oscillator that are asynchronous to ref_clk.
//
// Operation
// RQ1: Compare event starts conversion only with mode 1011 and converter on.
// RQ2: Accepted trigger sets the go flag, starting conversion like software.
// RQ3: Each trigger clears the selected first or third timer counter.
// RQ4: Converter off: trigger ignored, go not set, no conversion.
// RQ5: Converter off: trigger still clears the selected timer counter.
// RQ6: Software selects channel, waits acquisition, then moves results out.
// RQ7: Control bits 7:6 clock, 5:3 channel, 2 go, 0 on; resets zero.
// RQ8: A conversion lasts twelve conversion-bit periods until result load.
// RQ9: Clearing go mid-conversion aborts; result pair keeps old value.
// RQ10: After abort wait two bit periods, then acquisition restarts.
// RQ11: Clock select gives 2..64 oscillator periods, or RC for 011.
// RQ12: Completion clears go, loads result, sets done flag.
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps

module adc_trigger_control (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [adc_trigger_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [adc_trigger_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [adc_trigger_pkg::DATA_W-1:0] hrdata,
  output logic irq,
  output logic irq_high_priority,
  input wire logic special_event,
  input wire logic [3:0] compare_unit_mode_field,
  input wire logic timer_select,
  output logic first_timer_clear,
  output logic third_timer_clear,
  input wire logic rc_osc,
  input wire logic [adc_trigger_pkg::CODE_W-1:0] analog_code,
  output logic [2:0] channel_select,
  output logic [3:0] port_analog_config,
  output logic acquire_active,
  output logic converting
);
  import adc_trigger_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] fmt;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [7:0] flags;
    logic [7:0] en;
    logic [7:0] prio;
    conv_state_e st;
    logic [5:0] div_cnt;
    logic [3:0] bit_cnt;
    logic rc_s1;
    logic rc_s2;
    logic rc_s3;
    logic [CODE_W-1:0] code_s1;
    logic [CODE_W-1:0] code_s2;
    logic a_valid;
    logic a_write;
    logic a_hit;
    logic [7:0] a_addr;
    logic rd_wait;
    logic [DATA_W-1:0] rdata;
    logic t1_clr;
    logic t3_clr;
  } ctl_s;

  ctl_s r_reg;
  ctl_s r_next;

  // Shift is 2*low+high, giving 2,4,8,16,32,64 oscillator periods
  function automatic logic [5:0] tad_last(input logic [2:0] sel);
    logic [6:0] p;
    p = 7'h02 << {sel[1:0], sel[2]};
    tad_last = 6'(p - 7'h01);
  endfunction

  logic [2:0] clk_sel;
  logic rc_mode;
  logic tad_tick;
  logic trig;
  logic accepted;
  logic wr;
  logic wr_ctrl;
  logic go_w;
  logic [7:0] rd_mux;
  logic [CODE_W-1:0] code;

  assign clk_sel = {r_reg.fmt[FMT_CLK_HI_BIT], r_reg.ctrl[CTRL_CLK_LSB+:2]};
  assign rc_mode = (clk_sel[1:0] == 2'b11); // RQ11
  assign tad_tick = rc_mode ? (r_reg.rc_s2 & ~r_reg.rc_s3)
                            : (r_reg.div_cnt >= tad_last(clk_sel)); // RQ11
  assign trig = special_event && (compare_unit_mode_field == TRIG_MODE);
  assign accepted = trig && r_reg.ctrl[CTRL_ON_BIT]; // RQ1 RQ4
  assign wr = r_reg.a_valid && r_reg.a_write && r_reg.a_hit;
  assign wr_ctrl = wr && (r_reg.a_addr == OFF_CTRL_MAIN);
  // Go only sticks when the same write leaves the converter on
  assign go_w = hwdata[CTRL_GO_BIT] && hwdata[CTRL_ON_BIT];
  assign code = r_reg.code_s2;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always_comb begin
    rd_mux = 8'h00;
    if (r_reg.a_hit) begin
      unique case (r_reg.a_addr)
        OFF_CTRL_MAIN: rd_mux = r_reg.ctrl;
        OFF_CTRL_FMT: rd_mux = r_reg.fmt;
        OFF_RES_UPPER: rd_mux = r_reg.res_hi;
        OFF_RES_LOWER: rd_mux = r_reg.res_lo;
        OFF_FLAGS: rd_mux = r_reg.flags;
        OFF_ENABLES: rd_mux = r_reg.en;
        OFF_PRIORITY: rd_mux = r_reg.prio;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    r_next = r_reg;
    r_next.t1_clr = trig && !timer_select; // RQ3 RQ5
    r_next.t3_clr = trig && timer_select; // RQ3 RQ5
    r_next.rc_s1 = rc_osc;
    r_next.rc_s2 = r_reg.rc_s1;
    r_next.rc_s3 = r_reg.rc_s2;
    r_next.code_s1 = analog_code;
    r_next.code_s2 = r_reg.code_s1;
    r_next.div_cnt = tad_tick ? 6'h00 : 6'(r_reg.div_cnt + 6'h01);

    // Bus: reads take one wait state so a write just before is seen
    r_next.rd_wait = 1'b0;
    if (r_reg.rd_wait) begin
      r_next.rdata = {24'h000000, rd_mux};
    end
    if (hready) begin
      r_next.a_valid = hsel && htrans[1];
      r_next.a_write = hwrite;
      r_next.a_hit = (haddr[ADDR_W-1:8] == 24'h000000) &&
                     (haddr[1:0] == 2'b00);
      r_next.a_addr = haddr[7:0];
      r_next.rd_wait = hsel && htrans[1] && !hwrite;
    end

    // Register writes
    if (wr_ctrl) begin
      r_next.ctrl = hwdata[7:0] & CTRL_MASK; // RQ7
      r_next.ctrl[CTRL_GO_BIT] = go_w;
    end
    if (wr && r_reg.a_addr == OFF_CTRL_FMT) begin
      r_next.fmt = hwdata[7:0] & FMT_MASK;
    end
    if (wr && r_reg.a_addr == OFF_RES_UPPER) begin
      r_next.res_hi = hwdata[7:0];
    end
    if (wr && r_reg.a_addr == OFF_RES_LOWER) begin
      r_next.res_lo = hwdata[7:0];
    end
    if (wr && r_reg.a_addr == OFF_ENABLES) begin
      r_next.en = hwdata[7:0] & FLAG_MASK;
    end
    if (wr && r_reg.a_addr == OFF_PRIORITY) begin
      r_next.prio = hwdata[7:0] & FLAG_MASK;
    end
    if (wr && r_reg.a_addr == OFF_FLAG_CLEAR) begin
      r_next.flags = r_reg.flags & ~hwdata[7:0];
    end

    // Hardware set of go wins over a software clear in the same cycle
    if (accepted) begin
      r_next.ctrl[CTRL_GO_BIT] = 1'b1; // RQ2
    end

    // Sequencer
    unique case (r_reg.st)
      ST_ACQUIRE: begin
        if (r_reg.ctrl[CTRL_GO_BIT] && r_reg.ctrl[CTRL_ON_BIT]) begin
          r_next.st = ST_CONVERT; // RQ2
          r_next.bit_cnt = 4'h0;
          r_next.div_cnt = 6'h00;
        end
      end
      ST_CONVERT: begin
        if (wr_ctrl && !go_w && !accepted) begin
          // Abort: result pair is left untouched
          r_next.st = ST_ABORT_WAIT; // RQ9
          r_next.bit_cnt = 4'h0;
          r_next.div_cnt = 6'h00;
        end else if (tad_tick) begin
          if (r_reg.bit_cnt == CONV_TADS - 4'h1) begin
            r_next.st = ST_ACQUIRE; // RQ8
            r_next.ctrl[CTRL_GO_BIT] = accepted ||
                                       (wr_ctrl && go_w); // RQ12
            r_next.flags[FLAG_DONE_BIT] = 1'b1; // RQ12
            if (r_reg.fmt[FMT_JUSTIFY_BIT]) begin
              r_next.res_hi = {6'h00, code[9:8]};
              r_next.res_lo = code[7:0];
            end else begin
              r_next.res_hi = code[9:2];
              r_next.res_lo = {code[1:0], 6'h00};
            end
          end else begin
            r_next.bit_cnt = 4'(r_reg.bit_cnt + 4'h1);
          end
        end
      end
      ST_ABORT_WAIT: begin
        if (tad_tick) begin
          if (r_reg.bit_cnt == ABORT_TADS - 4'h1) begin
            r_next.st = ST_ACQUIRE; // RQ10
          end else begin
            r_next.bit_cnt = 4'(r_reg.bit_cnt + 4'h1);
          end
        end
      end
      default: r_next.st = ST_ACQUIRE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      r_reg <= '0; // RQ7
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hreadyout = !r_reg.rd_wait;
  assign hresp = 1'b0;
  assign hrdata = r_reg.rdata;
  assign irq = |(r_reg.flags & r_reg.en);
  assign irq_high_priority = |(r_reg.flags & r_reg.en & r_reg.prio);
  assign first_timer_clear = r_reg.t1_clr;
  assign third_timer_clear = r_reg.t3_clr;
  assign channel_select = r_reg.ctrl[CTRL_CHAN_LSB+:3];
  assign port_analog_config = r_reg.fmt[3:0];
  assign acquire_active = (r_reg.st == ST_ACQUIRE) && r_reg.ctrl[CTRL_ON_BIT];
  assign converting = (r_reg.st == ST_CONVERT);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_trig_sets_go: assert property ( // RQ2
    trig && r_reg.ctrl[CTRL_ON_BIT] |=> r_reg.ctrl[CTRL_GO_BIT] ##1
      (r_reg.st == ST_CONVERT || $past(r_reg.st) == ST_CONVERT))
    else $error("accepted trigger did not start a conversion");

  a_wrong_mode_ignored: assert property ( // RQ1
    special_event && compare_unit_mode_field != TRIG_MODE &&
      !wr_ctrl && !r_reg.ctrl[CTRL_GO_BIT]
    |=> !r_reg.ctrl[CTRL_GO_BIT] && !first_timer_clear &&
      !third_timer_clear)
    else $error("event outside trigger mode had an effect");

  a_off_ignores_trig: assert property ( // RQ4
    trig && !r_reg.ctrl[CTRL_ON_BIT] && !wr_ctrl
    |=> !r_reg.ctrl[CTRL_GO_BIT] && r_reg.st != ST_CONVERT)
    else $error("trigger honoured while converter off");

  a_timer_clear_sel: assert property ( // RQ3 RQ5
    trig |=> (first_timer_clear == !$past(timer_select)) &&
      (third_timer_clear == $past(timer_select)))
    else $error("selected timer not cleared on trigger");

  a_reset_ctrl_zero: assert property ( // RQ7
    $rose(rst_b) |-> r_reg.ctrl == CTRL_RESET && r_reg.fmt == FMT_RESET)
    else $error("control registers not zero after reset");

  a_ctrl_bit1_zero: assert property ( // RQ7
    r_reg.ctrl[1] == 1'b0 && (r_reg.ctrl[CTRL_GO_BIT] ->
      r_reg.ctrl[CTRL_ON_BIT] || r_reg.st == ST_CONVERT))
    else $error("unimplemented control bit set");

  a_conv_done: assert property ( // RQ8 RQ12
    r_reg.st == ST_CONVERT && tad_tick &&
      r_reg.bit_cnt == CONV_TADS - 4'h1 &&
      !wr && !accepted
    |=> r_reg.st == ST_ACQUIRE && !r_reg.ctrl[CTRL_GO_BIT] &&
      r_reg.flags[FLAG_DONE_BIT])
    else $error("conversion did not complete after twelve periods");

  a_abort_keeps: assert property ( // RQ9
    r_reg.st == ST_CONVERT && wr_ctrl && !go_w && !accepted
    |=> r_reg.st == ST_ABORT_WAIT && $stable(r_reg.res_hi) &&
      $stable(r_reg.res_lo))
    else $error("abort changed result or missed wait");

  a_abort_wait: assert property ( // RQ10
    r_reg.st == ST_ABORT_WAIT && tad_tick &&
      r_reg.bit_cnt == ABORT_TADS - 4'h1
    |=> r_reg.st == ST_ACQUIRE)
    else $error("acquisition did not restart after abort wait");

  // A state change or reset restarts the divider, so skip ticks after one
  a_tad_two: assert property ( // RQ11
    tad_tick && clk_sel == 3'b000 && $past(clk_sel) == 3'b000 &&
      $past(clk_sel, 2) == 3'b000 && r_reg.st == $past(r_reg.st) &&
      r_reg.st == $past(r_reg.st, 2) && $past(rst_b, 2)
    |-> !$past(tad_tick) && $past(tad_tick, 2))
    else $error("two-period bit clock wrong");

  a_irq_level: assert property (
    r_reg.flags[FLAG_DONE_BIT] && r_reg.en[FLAG_DONE_BIT] |-> irq)
    else $error("enabled flag without interrupt");

  a_sw_go_starts: assert property ( // RQ2
    wr_ctrl && go_w && r_reg.st == ST_ACQUIRE
    |=> r_reg.ctrl[CTRL_GO_BIT])
    else $error("software go write did not set go");

  a_result_held: assert property ( // RQ9
    !wr && !(r_reg.st == ST_CONVERT && tad_tick &&
      r_reg.bit_cnt == CONV_TADS - 4'h1)
    |=> $stable(r_reg.res_hi) && $stable(r_reg.res_lo))
    else $error("result pair changed outside completion");

  a_read_one_wait: assert property (
    hsel && htrans[1] && !hwrite && hready
    |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

  c_trig_start: cover property (accepted ##[1:3] converting);
  c_conv_done: cover property (converting ##1
    $rose(r_reg.flags[FLAG_DONE_BIT]));
  c_rc_conv: cover property (rc_mode && converting ##1 !converting);
  c_abort: cover property (r_reg.st == ST_ABORT_WAIT ##[1:300]
    r_reg.st == ST_ACQUIRE);
  c_trig_off: cover property (trig && !r_reg.ctrl[CTRL_ON_BIT]);

endmodule

//--- core/adc_trigger_pkg.sv
// Constants shared by the converter trigger and control block.
// Assumes a single 32-bit AHB-Lite bus clocked by the block clock.
package adc_trigger_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int CODE_W = 10;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL_MAIN = 8'h00;
  localparam logic [7:0] OFF_CTRL_FMT = 8'h04;
  localparam logic [7:0] OFF_RES_UPPER = 8'h08;
  localparam logic [7:0] OFF_RES_LOWER = 8'h0c;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_ENABLES = 8'h14;
  localparam logic [7:0] OFF_PRIORITY = 8'h18;
  localparam logic [7:0] OFF_FLAG_CLEAR = 8'h1c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_GO_BIT = 2;
  localparam int CTRL_CHAN_LSB = 3;
  localparam int CTRL_CLK_LSB = 6;
  localparam int FMT_JUSTIFY_BIT = 7;
  localparam int FMT_CLK_HI_BIT = 6;
  localparam int FLAG_DONE_BIT = 6;

  // ****************************************************************
  // Reset values and implemented-bit masks
  // ****************************************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] FMT_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'hfd;
  localparam logic [7:0] FMT_MASK = 8'hcf;
  localparam logic [7:0] FLAG_MASK = 8'h40;

  // ****************************************************************
  // Trigger and timing counts
  // ****************************************************************
  localparam logic [3:0] TRIG_MODE = 4'hb;
  localparam logic [3:0] CONV_TADS = 4'd12;
  localparam logic [3:0] ABORT_TADS = 4'd2;

  typedef enum logic [1:0] {
    ST_ACQUIRE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_ABORT_WAIT = 2'b11
  } conv_state_e;

endpackage

//--- tb/compare_partner.sv
// Compare unit and timer pair facing the converter trigger inputs.
// Assumes the bench requests events synchronously to ref_clk.
`timescale 1ns/1ps

module compare_partner (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic fire,
  input wire logic [3:0] mode_req,
  input wire logic sel_req,
  output logic special_event,
  output logic [3:0] compare_unit_mode_field,
  output logic timer_select,
  input wire logic first_timer_clear,
  input wire logic third_timer_clear,
  output logic [15:0] first_count,
  output logic [15:0] third_count
);
  // ********
  // Event path and free-running timers
  // ********
  assign special_event = fire;
  assign compare_unit_mode_field = mode_req;
  assign timer_select = sel_req;
  // Nonzero start so a missed clear stays visible
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      first_count <= 16'h0100;
      third_count <= 16'h0200;
    end else begin
      first_count <= first_timer_clear ? 16'h0 : first_count + 16'h1;
      third_count <= third_timer_clear ? 16'h0 : third_count + 16'h1;
    end
  end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the converter trigger and control block.
// Assumes one AHB-Lite master, hready tied to hreadyout.
`timescale 1ns/1ps

module testbench;
  import adc_trigger_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rc_osc = 1'b0;
  logic fire = 1'b0;
  logic sel_req = 1'b0;
  logic rd_dp = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [3:0] mode_req = 4'h0;
  logic [9:0] analog_code = 10'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rnd = 32'h31c2;
  logic hreadyout, hresp, irq, irq_high_priority, special_event;
  logic timer_select, first_timer_clear, third_timer_clear;
  logic acquire_active, converting;
  logic [31:0] hrdata;
  logic [3:0] compare_unit_mode_field, port_analog_config;
  logic [2:0] channel_select;
  logic [15:0] first_count, third_count;
  logic [31:0] exp_q[$];
  logic [2:0] sels [7] = '{3'd0, 3'd4, 3'd1, 3'd5, 3'd2, 3'd6, 3'd3};
  int per [7] = '{2, 4, 8, 16, 32, 64, 0};
  int fails = 0;
  int check_count = 0;
  int cyc = 0;

  adc_trigger_control u_adc_trigger_control (.ref_clk(ref_clk),
    .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .irq_high_priority(irq_high_priority), .special_event(special_event),
    .compare_unit_mode_field(compare_unit_mode_field),
    .timer_select(timer_select), .first_timer_clear(first_timer_clear),
    .third_timer_clear(third_timer_clear), .rc_osc(rc_osc),
    .analog_code(analog_code), .channel_select(channel_select),
    .port_analog_config(port_analog_config),
    .acquire_active(acquire_active), .converting(converting));

  compare_partner u_compare_partner (.ref_clk(ref_clk), .rst_b(rst_b),
    .fire(fire), .mode_req(mode_req), .sel_req(sel_req),
    .special_event(special_event),
    .compare_unit_mode_field(compare_unit_mode_field),
    .timer_select(timer_select), .first_timer_clear(first_timer_clear),
    .third_timer_clear(third_timer_clear), .first_count(first_count),
    .third_count(third_count));

  // ********
  // Clock, slow RC source, hang guard
  // ********
  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc % 5 == 0) begin
      rc_osc <= ~rc_osc;
    end
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  // ********
  // Checking and bus tasks
  // ********
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Read data is judged by the monitor, in order of issue
  always @(posedge ref_clk) begin
    if (rd_dp && hreadyout) begin
      check("hrdata", hrdata, exp_q.pop_front());
      check("hresp", {31'h0, hresp}, 32'h0);
    end
  end

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] e);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsel <= 1'b1;
    @(posedge ref_clk);
    while (!hreadyout) @(posedge ref_clk);
    htrans <= 2'b00;
    hwdata <= d;
    if (!wr) begin
      exp_q.push_back(e);
      rd_dp <= 1'b1;
    end
    @(posedge ref_clk);
    while (!hreadyout) @(posedge ref_clk);
    rd_dp <= 1'b0;
  endtask

  task automatic conv(input int p, input logic chk);
    int n;
    n = 0;
    while (!converting && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    n = 0;
    while (converting && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    if (chk) check("conv_cycles", 32'(n), 32'(12 * p));
  endtask

  task automatic trig(input logic [3:0] m, input logic s);
    mode_req <= m;
    sel_req <= s;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    logic [2:0] s;
    logic j;
    logic [9:0] c;
    logic [3:0] m;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    bus(0, OFF_CTRL_MAIN, 0, 32'h0);
    bus(0, OFF_CTRL_FMT, 0, 32'h0);
    bus(0, OFF_FLAGS, 0, 32'h0);
    bus(1, OFF_CTRL_MAIN, 32'h0b, 0);
    bus(0, OFF_CTRL_MAIN, 0, 32'h09);
    bus(0, 8'h20, 0, 32'h0);
    bus(1, OFF_CTRL_FMT, 32'hff, 0);
    bus(0, OFF_CTRL_FMT, 0, {24'h0, FMT_MASK});
    check("port_cfg", {28'h0, port_analog_config}, 32'hf);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      s = sels[i];
      j = i[0];
      rnd = xs(rnd);
      c = rnd[9:0];
      analog_code <= c;
      bus(1, OFF_CTRL_FMT, {24'h0, j, s[2], 6'h0}, 0);
      bus(1, OFF_CTRL_MAIN, {24'h0, s[1:0], 3'(i), 3'b101}, 0);
      // The write landed at the last edge inside bus; look one edge later once it has settled
      @(posedge ref_clk);
      check("chan", {29'h0, channel_select}, 32'(i));
      conv(per[i], s != 3'b011);
      bus(0, OFF_CTRL_MAIN, 0, {24'h0, s[1:0], 3'(i), 3'b001});
      bus(0, OFF_RES_UPPER, 0,
          j ? {30'h0, c[9:8]} : {24'h0, c[9:2]});
      bus(0, OFF_RES_LOWER, 0,
          j ? {24'h0, c[7:0]} : {24'h0, c[1:0], 6'h0});
      bus(0, OFF_FLAGS, 0, 32'h40);
      bus(1, OFF_FLAG_CLEAR, 32'h40, 0);
    end
    $display("test conversions done");
    bus(1, OFF_CTRL_FMT, 0, 0);
    bus(1, OFF_CTRL_MAIN, 32'h11, 0);
    repeat (20) @(posedge ref_clk);
    trig(TRIG_MODE, 1'b0);
    check("t1_clear", {31'h0, first_count < 16'd4}, 1);
    check("conv_trig", {31'h0, converting}, 1);
    conv(2, 1'b0);
    bus(0, OFF_CTRL_MAIN, 0, 32'h11);
    bus(1, OFF_CTRL_MAIN, 32'h10, 0);
    trig(TRIG_MODE, 1'b1);
    check("t3_clear", {31'h0, third_count < 16'd4}, 1);
    check("conv_off", {31'h0, converting}, 0);
    bus(0, OFF_CTRL_MAIN, 0, 32'h10);
    bus(1, OFF_CTRL_MAIN, 32'h11, 0);
    rnd = xs(rnd);
    m = (rnd[3:0] == TRIG_MODE) ? 4'ha : rnd[3:0];
    trig(m, 1'b0);
    check("t1_kept", {31'h0, first_count < 16'd4}, 0);
    check("conv_mode", {31'h0, converting}, 0);
    $display("test trigger done");
    check("irq_masked", {31'h0, irq}, 0);
    bus(1, OFF_ENABLES, 32'h40, 0);
    bus(1, OFF_FLAGS, 32'h0, 0);
    @(posedge ref_clk);
    check("irq_on", {31'h0, irq}, 1);
    check("irq_hp_off", {31'h0, irq_high_priority}, 0);
    bus(1, OFF_PRIORITY, 32'h40, 0);
    @(posedge ref_clk);
    check("irq_hp_on", {31'h0, irq_high_priority}, 1);
    bus(1, OFF_FLAG_CLEAR, 32'h40, 0);
    @(posedge ref_clk);
    check("irq_clr", {31'h0, irq}, 0);
    $display("test interrupt done");
    bus(1, OFF_CTRL_FMT, 32'h40, 0);
    bus(1, OFF_RES_UPPER, 32'h5a, 0);
    bus(1, OFF_CTRL_MAIN, 32'h85, 0);
    repeat (50) @(posedge ref_clk);
    bus(1, OFF_CTRL_MAIN, 32'h81, 0);
    @(posedge ref_clk);
    check("abort", {31'h0, converting}, 0);
    bus(0, OFF_RES_UPPER, 0, 32'h5a);
    repeat (100) @(posedge ref_clk);
    check("acq_wait", {31'h0, acquire_active}, 0);
    repeat (40) @(posedge ref_clk);
    check("acq_back", {31'h0, acquire_active}, 1);
    $display("test abort done");
    end_sim();
  end
endmodule
